// ---- pkg/asrp_pkg.sv ----
// constants and types of the block
`default_nettype none
package asrp_pkg;
   localparam int CLK_HZ            = 25_000_000;
   localparam int CLK_PER_US        = CLK_HZ / 1_000_000;
   localparam int REENABLE_NS       = 4000;
   localparam int REENABLE_CYCLES   = REENABLE_NS * CLK_PER_US / 1000;
   localparam int RESET_MIN_NS      = 300;
   localparam int RESET_HOLD_CYCLES = (RESET_MIN_NS * CLK_PER_US + 999) / 1000;
   localparam int SECOND_CYCLES     = CLK_HZ;
   localparam int MS_CYCLES         = CLK_HZ / 1000;
   localparam int SETTLE_CYCLES     = 3;
   // 10 MHz over 25 MHz: add 4, wrap at 5 per divisor step
   localparam int FREQ_ACC_STEP     = 4;
   localparam int FREQ_ACC_UNIT     = 5;
   localparam logic [8:0]  WIDTH_MIN_MS   = 9'h001;
   localparam logic [8:0]  WIDTH_MAX_MS   = 9'h1F4;
   localparam logic [8:0]  WIDTH_RESET    = 9'h064;
   localparam logic [15:0] BAUD_DIV_RESET = 16'h00D8;
   localparam logic [7:0] OFS_CTRL        = 8'h00;
   localparam logic [7:0] OFS_WIDTH       = 8'h04;
   localparam logic [7:0] OFS_CABLE_DELAY = 8'h08;
   localparam logic [7:0] OFS_FREQ_DIV    = 8'h0C;
   localparam logic [7:0] OFS_ANT_STATUS  = 8'h10;
   localparam logic [7:0] OFS_EVENT_SEC   = 8'h14;
   localparam logic [7:0] OFS_EVENT_SUB   = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h20;
   localparam logic [7:0] OFS_BAUD_A      = 8'h24;
   localparam logic [7:0] OFS_BAUD_B      = 8'h28;
   localparam logic [7:0] OFS_TX_A        = 8'h2C;
   localparam logic [7:0] OFS_TX_B        = 8'h30;
   localparam logic [7:0] OFS_SERIAL_STAT = 8'h34;
   localparam int CTRL_PULSE_EN = 0;
   localparam int CTRL_POLARITY = 1;
   localparam int CTRL_EVEN_SEC = 2;
   localparam int CTRL_SW_RESET = 3;
   localparam logic [2:0] CTRL_RESET = 3'h1;
   localparam int IRQ_EVENT  = 0;
   localparam int IRQ_ANT    = 1;
   localparam int IRQ_SECOND = 2;
   localparam int IRQ_W      = 3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      ANT_NORMAL  = 2'h0,
      ANT_OPEN    = 2'h1,
      ANT_SHORTED = 2'h2,
      ANT_UNDEF   = 2'h3
   } asrp_ant_t;
   typedef enum logic [1:0] {
      REEN_IDLE   = 2'h0,
      REEN_DRIVE  = 2'h1,
      REEN_SETTLE = 2'h2
   } asrp_reen_t;
endpackage
`default_nettype wire

// ---- verilog/asrp_serial_tx.sv ----
// serial transmitter, 8 data bits, 1 stop bit
`default_nettype none
module asrp_serial_tx #(
   parameter int DIV_W = 16
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // control
   input  wire logic [DIV_W-1:0] baud_div,
   input  wire logic             start,
   input  wire logic [7:0]       data,
   // line and state
   output var  logic             tx_line,
   output var  logic             busy
);
   logic [DIV_W-1:0] baud_cnt;
   logic [9:0]       shift;
   logic [3:0]       bits_left;

   // each bit stands baud_div+1 cycles; a start while busy is dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_line   <= 1'b1;
         busy      <= 1'b0;
         baud_cnt  <= '0;
         shift     <= 10'h3FF;
         bits_left <= 4'h0;
      end else if (!busy) begin
         if (start) begin
            shift     <= {1'b1, data, 1'b0};
            bits_left <= 4'hA;
            busy      <= 1'b1;
            baud_cnt  <= '0;
         end
      end else if (baud_cnt != '0) begin
         baud_cnt <= baud_cnt - 1'b1;
      end else if (bits_left == 4'h0) begin
         busy <= 1'b0;
      end else begin
         tx_line   <= shift[0];
         shift     <= {1'b1, shift[9:1]};
         bits_left <= bits_left - 4'h1;
         baud_cnt  <= baud_div;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/asrp_top.sv ----
// antenna sensing, reset pin, timing pulse and serial ports behind an AXI4-Lite slave
//
// Functional notes
// - short line is an input; after power-up or short, drive high 4 us each second
// - decode short/open levels: 11 open, 10 normal, 00 shorted, 01 undefined; report it
// - reset pin low keeps the device in reset; pull-up keeps it high otherwise
// - software reset drives the reset pin low from inside
// - 1 Hz timing pulse by default, optionally an even-second pulse instead
// - timing pulse high time programmable from 1 ms to 500 ms
// - host sets cable delay, enable and polarity, applied to the pulse output
// - timing pin may give 10 MHz divided by an integer
// - both serial ports run at a baud rate the user selects
// - timestamp each event rising edge and offer it to the host
`default_nettype none
module asrp_top #(
   parameter int SECOND_CYCLES = asrp_pkg::SECOND_CYCLES,
   parameter int MS_CYCLES     = asrp_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // antenna sensing
   input  wire logic        antenna_open_input,
   input  wire logic        antenna_short_line_in,
   output wire logic        antenna_short_line_out,
   output wire logic        antenna_short_line_oe,
   // open-drain reset pin
   input  wire logic        reset_pin_in,
   output wire logic        reset_pin_out,
   output var  logic        reset_pin_oe,
   // timing pulse and event
   output var  logic        second_pulse_out,
   input  wire logic        event_input,
   // serial ports
   input  wire logic        serial_a_receive,
   input  wire logic        serial_b_receive,
   output wire logic        serial_a_transmit,
   output wire logic        serial_b_transmit,
   // interrupt
   output var  logic        irq
);
   localparam int SEC_W = $clog2(SECOND_CYCLES);

   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return res;
   endfunction

   function automatic asrp_pkg::asrp_ant_t decode_ant(input logic short_lv,
                                                       input logic open_lv);
      case ({short_lv, open_lv})
         2'h3:    return asrp_pkg::ANT_OPEN;
         2'h2:    return asrp_pkg::ANT_NORMAL;
         2'h0:    return asrp_pkg::ANT_SHORTED;
         default: return asrp_pkg::ANT_UNDEF;
      endcase
   endfunction

   // pin low, ours or outside, resets the core
   wire core_rst = !aresetn || !reset_pin_in;

   // bus handshake
   logic              aw_full;
   logic              w_full;
   logic [7:0]        awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   wire               do_write = aw_full && w_full && !s_axi_bvalid;
   wire               ar_take  = s_axi_arvalid && s_axi_arready;
   wire               wr_known;
   wire               rd_known;
   wire [31:0]        rd_data;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= asrp_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full       <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full       <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? asrp_pkg::RESP_OKAY : asrp_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= asrp_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_known ? asrp_pkg::RESP_OKAY : asrp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // registers
   logic [2:0]             ctrl;
   logic [8:0]             width_ms;
   logic [23:0]            cable_delay;
   logic [15:0]            freq_div;
   logic [asrp_pkg::IRQ_W-1:0] irq_status;
   logic [asrp_pkg::IRQ_W-1:0] irq_mask;
   logic [15:0]            baud_div [2];
   logic [7:0]             tx_data  [2];
   logic [1:0]             tx_start;
   logic [1:0]             tx_busy;
   logic [asrp_pkg::IRQ_W-1:0] irq_set;
   asrp_pkg::asrp_ant_t    ant_status;
   logic [31:0]            sec_count;
   logic [31:0]            ev_sec;
   logic [31:0]            ev_sub;
   logic                   reen_active;

   wire [31:0] wr_word = merge_strb(32'h00000000, wdata_q, wstrb_q);
   wire wr_ctrl  = do_write && awaddr_q == asrp_pkg::OFS_CTRL;
   wire wr_irq   = do_write && awaddr_q == asrp_pkg::OFS_IRQ_STATUS;
   wire sw_reset = wr_ctrl && wr_word[asrp_pkg::CTRL_SW_RESET];
   assign wr_known = awaddr_q <= asrp_pkg::OFS_SERIAL_STAT && awaddr_q[1:0] == 2'h0;
   wire [7:0] rd_ofs = s_axi_araddr;
   assign rd_known = rd_ofs <= asrp_pkg::OFS_SERIAL_STAT && rd_ofs[1:0] == 2'h0;

   always_ff @(posedge aclk) begin
      if (core_rst) begin
         ctrl        <= asrp_pkg::CTRL_RESET;
         width_ms    <= asrp_pkg::WIDTH_RESET;
         cable_delay <= 24'h000000;
         freq_div    <= 16'h0000;
         irq_mask    <= '0;
         baud_div[0] <= asrp_pkg::BAUD_DIV_RESET;
         baud_div[1] <= asrp_pkg::BAUD_DIV_RESET;
         tx_data[0]  <= 8'h00;
         tx_data[1]  <= 8'h00;
         tx_start    <= 2'h0;
      end else begin
         tx_start <= 2'h0;
         if (do_write) begin
            case (awaddr_q)
               asrp_pkg::OFS_CTRL:        ctrl        <= wr_word[2:0];
               asrp_pkg::OFS_WIDTH:       width_ms    <= wr_word[8:0];
               asrp_pkg::OFS_CABLE_DELAY: cable_delay <= wr_word[23:0];
               asrp_pkg::OFS_FREQ_DIV:    freq_div    <= wr_word[15:0];
               asrp_pkg::OFS_IRQ_MASK:    irq_mask    <= wr_word[asrp_pkg::IRQ_W-1:0];
               asrp_pkg::OFS_BAUD_A:      baud_div[0] <= wr_word[15:0];
               asrp_pkg::OFS_BAUD_B:      baud_div[1] <= wr_word[15:0];
               asrp_pkg::OFS_TX_A: begin
                  tx_data[0]  <= wr_word[7:0];
                  tx_start[0] <= wstrb_q[0];
               end
               asrp_pkg::OFS_TX_B: begin
                  tx_data[1]  <= wr_word[7:0];
                  tx_start[1] <= wstrb_q[0];
               end
               default: ;
            endcase
         end
      end
   end

   // a hardware set wins over a same-cycle clear
   always_ff @(posedge aclk) begin
      if (core_rst) begin
         irq_status <= '0;
         irq        <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~(wr_irq ? wr_word[asrp_pkg::IRQ_W-1:0] : '0)) | irq_set;
         irq        <= |(irq_status & irq_mask);
      end
   end

   assign rd_data =
      (rd_ofs == asrp_pkg::OFS_CTRL)        ? {29'h0, ctrl} :
      (rd_ofs == asrp_pkg::OFS_WIDTH)       ? {23'h0, width_ms} :
      (rd_ofs == asrp_pkg::OFS_CABLE_DELAY) ? {8'h00, cable_delay} :
      (rd_ofs == asrp_pkg::OFS_FREQ_DIV)    ? {16'h0000, freq_div} :
      (rd_ofs == asrp_pkg::OFS_ANT_STATUS)  ? {29'h0, reen_active, ant_status} :
      (rd_ofs == asrp_pkg::OFS_EVENT_SEC)   ? ev_sec :
      (rd_ofs == asrp_pkg::OFS_EVENT_SUB)   ? ev_sub :
      (rd_ofs == asrp_pkg::OFS_IRQ_STATUS)  ? {29'h0, irq_status} :
      (rd_ofs == asrp_pkg::OFS_IRQ_MASK)    ? {29'h0, irq_mask} :
      (rd_ofs == asrp_pkg::OFS_BAUD_A)      ? {16'h0000, baud_div[0]} :
      (rd_ofs == asrp_pkg::OFS_BAUD_B)      ? {16'h0000, baud_div[1]} :
      (rd_ofs == asrp_pkg::OFS_TX_A)        ? {24'h000000, tx_data[0]} :
      (rd_ofs == asrp_pkg::OFS_TX_B)        ? {24'h000000, tx_data[1]} :
      (rd_ofs == asrp_pkg::OFS_SERIAL_STAT) ?
         {28'h0, serial_b_receive, serial_a_receive, tx_busy} : 32'h00000000;

   // software reset drive
   // aresetn only, so our own low cannot cut the drive short
   logic [3:0] rst_hold;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_hold     <= 4'h0;
         reset_pin_oe <= 1'b0;
      end else if (sw_reset) begin
         rst_hold     <= 4'(asrp_pkg::RESET_HOLD_CYCLES - 1);
         reset_pin_oe <= 1'b1;
      end else if (rst_hold != 4'h0) begin
         rst_hold <= rst_hold - 4'h1;
      end else begin
         reset_pin_oe <= 1'b0;
      end
   end
   assign reset_pin_out = 1'b0;

   // second time base
   logic [SEC_W-1:0] sec_cnt;
   logic             even_phase;
   wire              sec_wrap = sec_cnt == SEC_W'(SECOND_CYCLES - 1);
   always_ff @(posedge aclk) begin
      if (core_rst) begin
         sec_cnt    <= '0;
         sec_count  <= 32'h00000000;
         even_phase <= 1'b1;
      end else if (sec_wrap) begin
         sec_cnt    <= '0;
         sec_count  <= sec_count + 32'h1;
         even_phase <= !even_phase;
      end else begin
         sec_cnt <= sec_cnt + 1'b1;
      end
   end

   // timing pulse
   logic        pulse_hi;
   logic [31:0] hi_cnt;
   logic        sq_level;
   logic [19:0] freq_acc;
   wire  [8:0]  width_eff = (width_ms < asrp_pkg::WIDTH_MIN_MS) ? asrp_pkg::WIDTH_MIN_MS :
                            (width_ms > asrp_pkg::WIDTH_MAX_MS) ? asrp_pkg::WIDTH_MAX_MS :
                            width_ms;
   wire  [31:0] width_cyc = 32'(width_eff) * 32'(MS_CYCLES);
   wire         pulse_go  = (32'(sec_cnt) == 32'(cable_delay)) &&
                            (!ctrl[asrp_pkg::CTRL_EVEN_SEC] || even_phase);
   wire  [19:0] freq_lim  = 20'(freq_div) * 20'(asrp_pkg::FREQ_ACC_UNIT);
   wire  [19:0] acc_next  = freq_acc + 20'(asrp_pkg::FREQ_ACC_STEP);
   wire         freq_mode = freq_div != 16'h0000;
   wire         level     = freq_mode ? sq_level : pulse_hi;

   always_ff @(posedge aclk) begin
      if (core_rst) begin
         pulse_hi <= 1'b0;
         hi_cnt   <= 32'h00000000;
      end else if (pulse_go) begin
         pulse_hi <= 1'b1;
         hi_cnt   <= 32'h00000001;
      end else if (pulse_hi && hi_cnt >= width_cyc) begin
         pulse_hi <= 1'b0;
      end else begin
         hi_cnt <= hi_cnt + 32'h1;
      end
   end

   // toggling every 5N/4 clocks averages out to 10 MHz / N
   always_ff @(posedge aclk) begin
      if (core_rst || !freq_mode) begin
         freq_acc <= 20'h00000;
         sq_level <= 1'b0;
      end else if (acc_next >= freq_lim) begin
         freq_acc <= acc_next - freq_lim;
         sq_level <= !sq_level;
      end else begin
         freq_acc <= acc_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (core_rst) begin
         second_pulse_out <= 1'b0;
      end else begin
         second_pulse_out <= ctrl[asrp_pkg::CTRL_PULSE_EN] ?
                             (level ^ ctrl[asrp_pkg::CTRL_POLARITY]) :
                             ctrl[asrp_pkg::CTRL_POLARITY];
      end
   end

   // antenna sensing
   logic [1:0]           sense_s1;
   logic [1:0]           sense_s2;
   asrp_pkg::asrp_reen_t reen_state;
   logic [6:0]           reen_cnt;
   logic                 armed;
   wire asrp_pkg::asrp_ant_t ant_now = decode_ant(sense_s2[1], sense_s2[0]);

   always_ff @(posedge aclk) begin
      if (core_rst) begin
         sense_s1 <= 2'h2;
         sense_s2 <= 2'h2;
      end else begin
         sense_s1 <= {antenna_short_line_in, antenna_open_input};
         sense_s2 <= sense_s1;
      end
   end

   always_ff @(posedge aclk) begin
      if (core_rst) begin
         reen_state  <= asrp_pkg::REEN_IDLE;
         reen_cnt    <= 7'h00;
         reen_active <= 1'b0;
         armed       <= 1'b1;
         ant_status  <= asrp_pkg::ANT_NORMAL;
      end else begin
         case (reen_state)
            asrp_pkg::REEN_IDLE: begin
               ant_status <= ant_now;
               if (ant_now == asrp_pkg::ANT_SHORTED) armed <= 1'b1;
               if (armed && sec_wrap) begin
                  reen_state  <= asrp_pkg::REEN_DRIVE;
                  reen_cnt    <= 7'h00;
                  reen_active <= 1'b1;
               end
            end
            asrp_pkg::REEN_DRIVE: begin
               reen_cnt <= reen_cnt + 7'h01;
               if (reen_cnt == 7'(asrp_pkg::REENABLE_CYCLES - 1)) begin
                  reen_state  <= asrp_pkg::REEN_SETTLE;
                  reen_cnt    <= 7'h00;
                  reen_active <= 1'b0;
               end
            end
            asrp_pkg::REEN_SETTLE: begin
               // our own drive is still in the synchroniser; wait it out
               reen_cnt <= reen_cnt + 7'h01;
               if (reen_cnt == 7'(asrp_pkg::SETTLE_CYCLES - 1)) begin
                  reen_state <= asrp_pkg::REEN_IDLE;
                  armed      <= 1'b0;
               end
            end
            default: reen_state <= asrp_pkg::REEN_IDLE;
         endcase
      end
   end
   assign antenna_short_line_out = reen_active;
   assign antenna_short_line_oe  = reen_active;

   // event capture
   logic event_prev;
   wire  event_rise = event_input && !event_prev;
   always_ff @(posedge aclk) begin
      if (core_rst) begin
         event_prev <= 1'b0;
         ev_sec     <= 32'h00000000;
         ev_sub     <= 32'h00000000;
      end else begin
         event_prev <= event_input;
         if (event_rise) begin
            ev_sec <= sec_count;
            ev_sub <= 32'(sec_cnt);
         end
      end
   end

   assign irq_set[asrp_pkg::IRQ_EVENT]  = event_rise;
   assign irq_set[asrp_pkg::IRQ_ANT]    = reen_state == asrp_pkg::REEN_IDLE &&
                                          ant_now != ant_status;
   assign irq_set[asrp_pkg::IRQ_SECOND] = sec_wrap;

   // serial ports
   wire [1:0] tx_line;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_tx
         asrp_serial_tx #(.DIV_W(16)) u_tx (
            .aclk     (aclk),
            .aresetn  (!core_rst),
            .baud_div (baud_div[gi]),
            .start    (tx_start[gi]),
            .data     (tx_data[gi]),
            .tx_line  (tx_line[gi]),
            .busy     (tx_busy[gi])
         );
      end
   endgenerate
   assign serial_a_transmit = tx_line[0];
   assign serial_b_transmit = tx_line[1];
endmodule
`default_nettype wire

// ---- sim/asrp_chk.sv ----
// assertion checker of the block
`default_nettype none
module asrp_chk (
   // clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // bus handshakes
   input wire logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic       s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   // pins
   input wire logic       antenna_short_line_out, antenna_short_line_oe,
   input wire logic       reset_pin_in, reset_pin_out, reset_pin_oe, second_pulse_out,
   input wire logic       serial_a_transmit, serial_b_transmit
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] oe_n;
   // length of the current drive
   always_ff @(posedge aclk) begin
      oe_n <= (aresetn && antenna_short_line_oe) ? oe_n + 8'h01 : 8'h00;
   end
   property p_drive_hi; antenna_short_line_oe |-> antenna_short_line_out; endproperty
   a_drive_hi: assert property (p_drive_hi) else $error("short line not driven high");
   property p_reen_len;
      $fell(antenna_short_line_oe) && $past(reset_pin_in) |-> oe_n == 8'h64;
   endproperty
   a_reen_len: assert property (p_reen_len) else $error("re-enable length off");
   property p_reen_gap; $fell(antenna_short_line_oe) |-> !antenna_short_line_oe [*3]; endproperty
   a_reen_gap: assert property (p_reen_gap) else $error("short line redriven early");
   property p_sw_rst; $rose(reset_pin_oe) |-> reset_pin_oe [*8] ##1 !reset_pin_oe; endproperty
   a_sw_rst: assert property (p_sw_rst) else $error("reset pin drive length off");
   property p_pull_low; reset_pin_oe |-> !reset_pin_out; endproperty
   a_pull_low: assert property (p_pull_low) else $error("reset pin driven high");
   property p_pin_hold;
      !reset_pin_in |=> !second_pulse_out && !antenna_short_line_oe;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("outputs active in pin reset");
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_awready ##1 s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read response late");
   property p_tx_idle; $rose(aresetn) |-> serial_a_transmit && serial_b_transmit; endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("serial line not idle");
   c_reen: cover property ($rose(antenna_short_line_oe));
   c_swr: cover property ($rose(reset_pin_oe));
   c_pulse: cover property ($rose(second_pulse_out));
endmodule
bind asrp_top asrp_chk u_chk (.*);
`default_nettype wire

// ---- sim/asrp_partner.sv ----
// antenna detection circuit and host reset line
`default_nettype none
module asrp_partner (
   input  wire logic antenna_short_line_oe, antenna_short_line_out, reset_pin_oe, reset_pin_out,
   input  wire logic host_rst_n, open_lv, short_lv,
   output wire logic antenna_short_line_in, antenna_open_input, reset_pin_in
);
   // released short line shows the sensed level
   assign antenna_short_line_in = antenna_short_line_oe ? antenna_short_line_out : short_lv;
   assign antenna_open_input = open_lv;
   // host only pulls low; the pull-up gives the idle level
   assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || !host_rst_n);
endmodule
`default_nettype wire

// ---- sim/asrp_tb_top.sv ----
// self-checking bench of the block
`default_nettype none
module asrp_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'h0, aresetn = 1'h0, event_input = 1'h0, host_rst_n = 1'h1;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, open_lv = 1'h0, short_lv = 1'h1;
   logic serial_a_receive = 1'h1, serial_b_receive = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] rr;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic antenna_open_input, antenna_short_line_in, antenna_short_line_out;
   wire logic antenna_short_line_oe, reset_pin_in, reset_pin_out, reset_pin_oe;
   wire logic second_pulse_out, serial_a_transmit, serial_b_transmit;
   int err_count = 0, n_checks = 0, cyc = 0;
   asrp_top #(.SECOND_CYCLES(200), .MS_CYCLES(4)) dut (.*);
   asrp_partner u_far (.*);
   always #20 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 32'h4E20) begin
         err_count++;
         finish_test();
      end
   end
   task chk(input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("wrong value at %0t: %h, want %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'h0;
            rr = s_axi_bresp;
         end
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] m, e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rr = s_axi_rresp;
      chk(s_axi_rdata & m, e);
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask
   task t_regs;
      rchk(8'h00, 32'h7, 32'h1);
      rchk(8'h04, 32'h1FF, 32'h64);
      rchk(8'h24, 32'hFFFF, 32'hD8);
      wr(8'h28, 32'h3);
      rchk(8'h28, 32'hFFFF, 32'h3);
      wr(8'h04, 32'h0);
      rchk(8'h04, 32'h1FF, 32'h0);
      wr(8'h04, 32'h1F5);
      rchk(8'h04, 32'h1FF, 32'h1F5);
      wr(8'h2C, 32'h55);
      rchk(8'h34, 32'h1, 32'h1);
      chk(serial_a_transmit, 32'h0);
      wr(8'h3C, 32'h1);
      chk(rr, 32'h2);
      rchk(8'h3C, 32'hFFFFFFFF, 32'h0);
      chk(rr, 32'h2);
      $display("t_regs done");
   endtask
   task automatic t_ant;
      logic [1:0] e[4] = '{2'h2, 2'h3, 2'h0, 2'h1};
      for (int i = 0; i < 4; i++) begin
         {short_lv, open_lv} <= i[1:0];
         repeat (260) @(posedge aclk);
         rchk(8'h10, 32'h3, {30'h0, e[i]});
      end
      $display("t_ant done");
   endtask
   // one active phase and one period
   task automatic meas(input logic inv, input int eh, ep);
      int h = 0, p = 0;
      while (second_pulse_out ^ inv) @(posedge aclk);
      while (!(second_pulse_out ^ inv)) @(posedge aclk);
      while (second_pulse_out ^ inv) begin
         @(posedge aclk);
         h++;
      end
      while (!(second_pulse_out ^ inv)) begin
         @(posedge aclk);
         p++;
      end
      chk(h, eh);
      chk(h + p, ep);
   endtask
   task t_pulse;
      wr(8'h04, 32'hA);
      wr(8'h08, 32'h0);
      meas(1'h0, 40, 200);
      wr(8'h00, 32'h5);
      meas(1'h0, 40, 400);
      wr(8'h00, 32'h3);
      meas(1'h1, 40, 200);
      wr(8'h00, 32'h2);
      repeat (250) @(posedge aclk);
      chk(second_pulse_out, 32'h1);
      wr(8'h00, 32'h1);
      wr(8'h0C, 32'h4);
      meas(1'h0, 5, 10);
      wr(8'h0C, 32'h0);
      $display("t_pulse done");
   endtask
   task t_irq;
      wr(8'h20, 32'h1);
      wr(8'h1C, 32'h7);
      event_input <= 1'h1;
      repeat (4) @(posedge aclk);
      chk(irq, 32'h1);
      rchk(8'h1C, 32'h1, 32'h1);
      event_input <= 1'h0;
      wr(8'h1C, 32'h1);
      repeat (3) @(posedge aclk);
      chk(irq, 32'h0);
      wr(8'h20, 32'h0);
      event_input <= 1'h1;
      repeat (4) @(posedge aclk);
      chk(irq, 32'h0);
      $display("t_irq done");
   endtask
   task t_rst;
      wr(8'h04, 32'h14);
      wr(8'h00, 32'h8);
      chk(reset_pin_in, 32'h0);
      repeat (12) @(posedge aclk);
      rchk(8'h04, 32'h1FF, 32'h64);
      wr(8'h04, 32'h14);
      host_rst_n <= 1'h0;
      repeat (8) @(posedge aclk);
      host_rst_n <= 1'h1;
      repeat (2) @(posedge aclk);
      rchk(8'h04, 32'h1FF, 32'h64);
      $display("t_rst done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs();
      t_ant();
      t_pulse();
      t_irq();
      t_rst();
      finish_test();
   end
endmodule
`default_nettype wire
